/* verilog/ibs_pkg.sv */
// Constants for the channel-two bus-master status and pointer bank
package ibs_pkg;
    // ==========================================================
    // Register offsets within the bus-master I/O block
    localparam logic [3:0] IBS_OFF_RSVD_A = 4'h9;
    localparam logic [3:0] IBS_OFF_STATUS = 4'ha;
    localparam logic [3:0] IBS_OFF_RSVD_B = 4'hb;
    localparam logic [3:0] IBS_OFF_BASE0 = 4'hc;
    localparam logic [3:0] IBS_OFF_BASE1 = 4'hd;
    localparam logic [3:0] IBS_OFF_BASE2 = 4'he;
    localparam logic [3:0] IBS_OFF_BASE3 = 4'hf;
    // ==========================================================
    // Status field positions
    localparam int IBS_BIT_ACTIVE = 0;
    localparam int IBS_BIT_ERROR = 1;
    localparam int IBS_BIT_IRQ = 2;
    localparam int IBS_BIT_CAP1 = 3;
    localparam int IBS_BIT_CAP2 = 6;
    localparam int IBS_BIT_SIMPLEX = 7;
    // ==========================================================
    // Reset values
    localparam logic [7:0] IBS_STATUS_RST = 8'h00;
    localparam logic [29:0] IBS_BASE_RST = 30'h00000000;
    localparam logic [7:0] IBS_RDATA_RST = 8'h00;
    // ==========================================================
    // Register state of the bank
    typedef struct packed {
        logic active;
        logic error;
        logic irq;
        logic cap1;
        logic cap2;
        logic irq_sync1;
        logic irq_sync2;
        logic irq_prev;
        logic start_prev;
        logic [29:0] base;
        logic [7:0] rdata;
        logic run;
        logic abort;
        logic dir_write;
    } ibs_state_t;
endpackage : ibs_pkg

/* verilog/ibs_status_regs.sv */
// Channel-two bus-master status flags and descriptor-table pointer
`timescale 1ns/100ps
module ibs_status_regs
    import ibs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Byte register port
    input wire logic [3:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Command register and engine links
    input wire logic start_bit_in,
    input wire logic dir_bit_in,
    input wire logic drive_sel_in,
    input wire logic end_of_table_flag_done_in,
    input wire logic mem_error_in,
    // Drive interrupt pin
    input wire logic channel_two_drive_irq_in,
    // Status and control outputs
    output logic [7:0] status_out,
    output logic [31:0] descriptor_base_out,
    output logic dma_run_out,
    output logic dma_abort_out,
    output logic dma_dir_write_out
);
    // ==========================================================
    // State
    ibs_state_t cur;
    ibs_state_t nxt;
    logic irq_rise;
    logic start_rise;
    logic start_fall;
    logic status_wr;
    logic drive_cap;
    logic [7:0] status_view;

    // ==========================================================
    // Next-state logic
    always_comb begin
        nxt = cur;
        irq_rise = cur.irq_sync2 && !cur.irq_prev;
        start_rise = start_bit_in && !cur.start_prev;
        start_fall = !start_bit_in && cur.start_prev;
        status_wr = reg_wr_in && (reg_addr_in == IBS_OFF_STATUS);
        drive_cap = drive_sel_in ? cur.cap2 : cur.cap1;
        status_view = 8'h00;
        status_view[IBS_BIT_ACTIVE] = cur.active;
        status_view[IBS_BIT_ERROR] = cur.error;
        status_view[IBS_BIT_IRQ] = cur.irq;
        status_view[IBS_BIT_CAP1] = cur.cap1;
        status_view[IBS_BIT_CAP2] = cur.cap2;
        status_view[IBS_BIT_SIMPLEX] = 1'b0;

        // Pin passes two flops before the edge detector reads it
        nxt.irq_sync1 = channel_two_drive_irq_in;
        nxt.irq_sync2 = cur.irq_sync1;
        nxt.irq_prev = cur.irq_sync2;
        nxt.start_prev = start_bit_in;

        // Activity: stop and end-of-table win over a same-cycle start
        if (start_rise) begin
            nxt.active = 1'b1;
        end
        if (end_of_table_flag_done_in) begin
            nxt.active = 1'b0;
        end
        if (start_fall || !start_bit_in) begin
            nxt.active = 1'b0;
        end

        // Error and irq are write-one-clear, a same-cycle event keeps them set; cap bits take the written value
        if (status_wr && reg_wdata_in[IBS_BIT_ERROR]) begin
            nxt.error = 1'b0;
        end
        if (status_wr && reg_wdata_in[IBS_BIT_IRQ]) begin
            nxt.irq = 1'b0;
        end
        if (mem_error_in && cur.active) begin
            nxt.error = 1'b1;
        end
        if (irq_rise) begin
            nxt.irq = 1'b1;
        end
        if (status_wr) begin
            nxt.cap1 = reg_wdata_in[IBS_BIT_CAP1];
            nxt.cap2 = reg_wdata_in[IBS_BIT_CAP2];
        end

        // Pointer bytes; low two bits are not stored
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                IBS_OFF_BASE0: nxt.base[5:0] = reg_wdata_in[7:2];
                IBS_OFF_BASE1: nxt.base[13:6] = reg_wdata_in;
                IBS_OFF_BASE2: nxt.base[21:14] = reg_wdata_in;
                IBS_OFF_BASE3: nxt.base[29:22] = reg_wdata_in;
                default: begin
                end
            endcase
        end

        // Read answer one cycle after the strobe; unmapped reads zero
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                IBS_OFF_STATUS: nxt.rdata = status_view;
                IBS_OFF_BASE0: nxt.rdata = {cur.base[5:0], 2'b00};
                IBS_OFF_BASE1: nxt.rdata = cur.base[13:6];
                IBS_OFF_BASE2: nxt.rdata = cur.base[21:14];
                IBS_OFF_BASE3: nxt.rdata = cur.base[29:22];
                default: nxt.rdata = 8'h00;
            endcase
        end

        // Engine control: stop drops run and pulses abort at once; dir_write keeps following dir_bit_in
        nxt.abort = start_fall;
        nxt.run = nxt.active && start_bit_in && drive_cap;
        nxt.dir_write = dir_bit_in;

        if (!rst_n_in) begin
            nxt = '0;
            nxt.active = IBS_STATUS_RST[IBS_BIT_ACTIVE];
            nxt.error = IBS_STATUS_RST[IBS_BIT_ERROR];
            nxt.irq = IBS_STATUS_RST[IBS_BIT_IRQ];
            nxt.cap1 = IBS_STATUS_RST[IBS_BIT_CAP1];
            nxt.cap2 = IBS_STATUS_RST[IBS_BIT_CAP2];
            nxt.base = IBS_BASE_RST;
            nxt.rdata = IBS_RDATA_RST;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk_in) begin
        cur <= nxt;
    end

    // ==========================================================
    // Outputs straight from state flops
    always_comb begin
        reg_rdata_out = cur.rdata;
        status_out = {1'b0, cur.cap2, 2'b00, cur.cap1, cur.irq,
                      cur.error, cur.active};
        descriptor_base_out = {cur.base, 2'b00};
        dma_run_out = cur.run;
        dma_abort_out = cur.abort;
        dma_dir_write_out = cur.dir_write;
    end
endmodule : ibs_status_regs

/* verification/ibs_status_regs_sva.sv */
// Checker for the channel-two status and pointer bank
`timescale 1ns/100ps
module ibs_status_regs_sva
    import ibs_pkg::*;
(
    // Watched ports
    input logic sys_clk_in,
    input logic rst_n_in,
    input logic [3:0] reg_addr_in,
    input logic reg_wr_in,
    input logic [7:0] reg_wdata_in,
    input logic start_bit_in,
    input logic end_of_table_flag_done_in,
    input logic mem_error_in,
    input logic channel_two_drive_irq_in,
    input logic [7:0] status_out,
    input logic [31:0] descriptor_base_out,
    input logic dma_abort_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Two sync flops plus edge detect, so allow some slack
    sequence s_pin_rise;
        !channel_two_drive_irq_in ##1 channel_two_drive_irq_in;
    endsequence
    AST_ACT_SET: assert property ($rose(start_bit_in) &&
        !end_of_table_flag_done_in |=> status_out[0]) else $error("no set");
    AST_ACT_EOT: assert property (end_of_table_flag_done_in
        |=> !status_out[0]) else $error("eot kept active");
    AST_ACT_STOP: assert property (!start_bit_in
        |=> !status_out[0]) else $error("stop kept active");
    AST_ERR_SET: assert property (mem_error_in && status_out[0]
        |=> status_out[1]) else $error("error not set");
    AST_ERR_HOLD: assert property (status_out[1] && !(reg_wr_in &&
        reg_addr_in == IBS_OFF_STATUS && reg_wdata_in[1]) |=> status_out[1])
        else $error("error lost");
    AST_IRQ_HOLD: assert property (status_out[2] && !(reg_wr_in &&
        reg_addr_in == IBS_OFF_STATUS && reg_wdata_in[2]) |=> status_out[2])
        else $error("irq lost");
    AST_IRQ_SET: assert property (s_pin_rise
        |-> ##[1:5] status_out[2]) else $error("irq not set");
    AST_RSVD: assert property (!status_out[7] && !status_out[5])
        else $error("reserved bits set");
    AST_BASE_LOW: assert property (descriptor_base_out[1:0] == 2'h0)
        else $error("base low bits set");
    AST_ABORT: assert property ($fell(start_bit_in)
        |=> dma_abort_out) else $error("no abort");
endmodule : ibs_status_regs_sva
bind ibs_status_regs ibs_status_regs_sva u_sva (.*);

/* verification/ibs_status_regs_tb.sv */
// Self-checking bench for the status and pointer bank
`timescale 1ns/100ps
module ibs_status_regs_tb;
    import ibs_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, st = 1'b0;
    logic dir = 1'b0, ds = 1'b0, end_of_table_flag = 1'b0, me = 1'b0, irq = 1'b0;
    logic [3:0] a = 4'h0;
    logic [7:0] wd = 8'h00, rdat, stat;
    logic [31:0] base;
    logic run, abt, dw;
    int miscompares = 0, n_compared = 0;
    ibs_status_regs dut (.sys_clk_in(clk), .rst_n_in(rst_n),
        .reg_addr_in(a), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd),
        .reg_rdata_out(rdat), .start_bit_in(st), .dir_bit_in(dir),
        .drive_sel_in(ds), .end_of_table_flag_done_in(end_of_table_flag),
        .mem_error_in(me), .channel_two_drive_irq_in(irq),
        .status_out(stat), .descriptor_base_out(base), .dma_run_out(run),
        .dma_abort_out(abt), .dma_dir_write_out(dw));
    initial forever #4 clk = ~clk;
    // ==========================================================
    // Shared tasks
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr8(logic [3:0] ad, logic [7:0] d);
        @(posedge clk);
        a <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr8
    task automatic rd8(logic [3:0] ad, logic [7:0] e);
        @(posedge clk);
        a <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk("rdata", e, rdat);
    endtask : rd8
    // ==========================================================
    // Scenarios
    task automatic t_regs;
        rd8(IBS_OFF_STATUS, 8'h00);
        rd8(IBS_OFF_RSVD_A, 8'h00);
        wr8(IBS_OFF_STATUS, 8'hff);
        rd8(IBS_OFF_STATUS, 8'h48);
        wr8(IBS_OFF_BASE0, 8'h13);
        wr8(IBS_OFF_BASE1, 8'h57);
        wr8(IBS_OFF_BASE2, 8'h9b);
        wr8(IBS_OFF_BASE3, 8'hdf);
        rd8(IBS_OFF_BASE0, 8'h10);
        chk("base", 32'hdf9b5710, base);
    endtask : t_regs
    task automatic t_run;
        dir <= 1'b1;
        st <= 1'b1;
        cyc(2);
        chk("active", 1, stat[0]);
        chk("run", 1, run);
        chk("dir", 1, dw);
        me <= 1'b1;
        cyc(1);
        me <= 1'b0;
        cyc(1);
        wr8(IBS_OFF_STATUS, 8'h48);
        cyc(1);
        chk("error", 1, stat[1]);
        wr8(IBS_OFF_STATUS, 8'h4a);
        cyc(1);
        chk("error", 0, stat[1]);
        end_of_table_flag <= 1'b1;
        cyc(1);
        end_of_table_flag <= 1'b0;
        cyc(1);
        chk("active", 0, stat[0]);
        st <= 1'b0;
        cyc(2);
        chk("abort", 1, abt);
        wr8(IBS_OFF_STATUS, 8'h40);
        st <= 1'b1;
        cyc(2);
        chk("run", 0, run);
        ds <= 1'b1;
        cyc(2);
        chk("run", 1, run);
        st <= 1'b0;
        dir <= 1'b0;
        cyc(2);
        chk("active", 0, stat[0]);
        chk("dir", 0, dw);
    endtask : t_run
    task automatic t_irq;
        irq <= 1'b1;
        cyc(6);
        irq <= 1'b0;
        wr8(IBS_OFF_STATUS, 8'h00);
        cyc(1);
        chk("irq", 1, stat[2]);
        wr8(IBS_OFF_STATUS, 8'h04);
        cyc(1);
        chk("irq", 0, stat[2]);
        // Second edge lands with a clear; the set must win
        irq <= 1'b1;
        cyc(1);
        wr8(IBS_OFF_STATUS, 8'h04);
        cyc(1);
        chk("irq", 1, stat[2]);
        irq <= 1'b0;
    endtask : t_irq
    task automatic report_and_stop;
        $display("compared %0d wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        t_regs;
        t_run;
        t_irq;
        report_and_stop;
    end
    // Run takes about 64 cycles; cut a hang well after that
    initial begin
        cyc(2000);
        miscompares++;
        report_and_stop;
    end
endmodule : ibs_status_regs_tb
